// ==== pfl_pkg.sv ====
// Purpose: shared constants and types for the supply-loss lock-out controller
// Assumes: 125 MHz system clock, all pins asynchronous to it
// Notes:   timing figures are kept in microseconds and converted to cycles here
//
// Functional notes
// R1: supply loss needs 30-63 us debounce
// R2: debounced loss flags failing, raises interrupt
// R3: no delay option: lock bus within 63 us
// R4: delay option: bus usable 480 us, then lock
// R5: clearing delay option ends window at once
// R6: strobe held over 30 us forces lock; code forces it only if chip select was active at detection
// R7: locked: bus pins ignored, oscillator stays
// R8: timer pins ignored, outputs open drain standby
// R9: two bits keep timers, interrupts after failure
// R10: unlock only after high debounce again
// R11: masked interrupt still performs every lock-out
// R12: interrupt disable stops low battery detect
// R13: power-up sets oscillator fail, clears start
// R14: oscillator fail holds until clock started
// R15: single supply bit write keeps fail flag
// R16: time save enable copies counters continuously
// R17: time save cleared on battery switchover only
// R18: single supply: set bit, mask interrupt
// R19: status flag mirrors failing, no host clear
// R20: failing gated by chip select mid-access
// R21: two agreeing samples on 30 us tick
package pfl_pkg;
    // clock and timing figures
    localparam int CLK_MHZ      = 125;
    localparam int DEB_TICK_US  = 30;                       // sample spacing
    localparam int DEB_TICK_CYC = DEB_TICK_US * CLK_MHZ;    // 3750 cycles
    localparam int SAFE_US      = 30;                       // long-strobe limit
    localparam int SAFE_CYC     = SAFE_US * CLK_MHZ;        // 3750 cycles
    localparam int DELAY_US     = 480;                      // access window
    localparam int DELAY_CYC    = DELAY_US * CLK_MHZ;       // 60000 cycles
    localparam int CNT_W        = 12;                       // tick and safety counters

    // synchroniser bit positions
    localparam int S_FAIL  = 0;
    localparam int S_CS    = 1;
    localparam int S_RD    = 2;
    localparam int S_WR    = 3;
    localparam int S_SBY   = 4;
    localparam int S_LOWB  = 5;
    localparam int S_TCK   = 6;
    localparam int S_G0    = 7;
    localparam int S_G1    = 8;
    localparam int S_ADDR  = 9;
    localparam int S_DATA  = 14;
    localparam int SYNC_W  = 22;

    // reset values of the status bits
    localparam logic OSC_FAIL_RST  = 1'b1;
    localparam logic RTC_START_RST = 1'b0;

    // lock-out sequence
    typedef enum logic [1:0] {
        ST_RUN,
        ST_WINDOW,
        ST_LOCK_WAIT,
        ST_LOCKED
    } pfl_mode_type;

    // host bus as seen by the core, active high
    typedef struct packed {
        logic       cs;
        logic       rd;
        logic       wr;
        logic [4:0] addr;
        logic [7:0] data;
    } pfl_bus_type;

    // timer inputs as seen by the timer unit
    typedef struct packed {
        logic tck;
        logic gate0;
        logic gate1;
    } pfl_tmr_type;
endpackage

// ==== pfl_ctrl.sv ====
// Purpose: supply-loss debounce, bus lock-out and battery status control
// Assumes: pins are asynchronous; configuration bits come from the register file
// Notes:   the analogue comparators arrive as digital pins battery_supply and battery_low
`timescale 1ns/1ps
`default_nettype none
module pfl_ctrl
    import pfl_pkg::*;
#(
    parameter int WIN_W      = 16,          // width of the access window counter
    parameter int WINDOW_CYC = DELAY_CYC    // access window in cycles
) (
    input  wire logic        clk,              // 125 MHz clock
    input  wire logic        nrst,             // asynchronous reset, active low
    input  wire logic        supply_loss_n,    // supply monitor pin, low on loss
    input  wire logic        cs_n,             // host chip select pin
    input  wire logic        rd_n,             // host read strobe pin
    input  wire logic        wr_n,             // host write strobe pin
    input  wire logic [4:0]  addr_lines,       // host address pins
    input  wire logic [7:0]  data_lines,       // host data pins, input side
    input  wire logic        battery_supply,   // comparator: battery above main
    input  wire logic        battery_low,      // comparator: battery under 2.1V
    input  wire logic        timer_clk_in,     // external timer clock pin
    input  wire logic        timer_gate_zero,  // timer 0 gate pin
    input  wire logic        timer_gate_one,   // timer 1 gate pin
    input  wire logic        lockout_delay_en, // routing bit: delay lock-out
    input  wire logic        pf_irq_en,        // power fail interrupt enable
    input  wire logic        timer_pf_op,      // timers keep running on failure
    input  wire logic        irq_pf_op,        // interrupts keep running on failure
    input  wire logic        rtc_start_wr,     // pulse: software starts the clock
    input  wire logic        single_wr,        // pulse: write of single_supply_bit
    input  wire logic        single_wr_val,    // value written to single_supply_bit
    input  wire logic        ts_wr,            // pulse: write of time save enable
    input  wire logic        ts_wr_val,        // value written to time save enable
    output pfl_bus_type      bus_view,         // host bus after isolation
    output pfl_tmr_type      tmr_view,         // timer pins after isolation
    output logic             bus_locked,       // host interface isolated
    output logic             pf_status,        // power fail status flag
    output logic             pf_irq,           // power fail interrupt request
    output logic             low_batt_status,  // low battery status bit
    output logic             osc_fail,         // oscillator fail flag
    output logic             rtc_start,        // real-time clock start bit
    output logic             single_supply_bit,// single supply selection
    output logic             linear_on,        // linear detection circuits enabled
    output logic             time_save_en,     // time save enable bit
    output logic             time_save_copy,   // copy counters into save RAM
    output logic             timers_run,       // timer unit allowed to run
    output logic             irq_logic_run,    // interrupt logic allowed to run
    output logic             outputs_od        // irq and timer outputs open drain
);
    // refuse a window counter that cannot hold the window; one cycle is no window at all
    if (WINDOW_CYC < 2 || WINDOW_CYC > (2 ** WIN_W) - 1) begin : g_bad_window
        $error("pfl_ctrl: WINDOW_CYC does not fit WIN_W");
    end

    typedef struct packed {
        logic [SYNC_W-1:0] s1;        // first synchroniser stage
        logic [SYNC_W-1:0] s2;        // second synchroniser stage
        logic [CNT_W-1:0]  tick_cnt;  // debounce sample divider
        logic              samp;      // last debounce sample, high = failing
        logic              failing;   // debounced supply loss
        pfl_mode_type      mode;
        logic [WIN_W-1:0]  win_cnt;   // access window progress
        logic              safe_arm;  // chip select active at detection
        logic [CNT_W-1:0]  safe_cnt;  // continuous strobe length
        logic              irq;
        logic              osc_fail;
        logic              rtc_start;
        logic              single;
        logic              ts_en;
        logic              sby_prev;
        logic              low_batt;
        pfl_bus_type       bus;
        pfl_tmr_type       tmr;
    } pfl_state_type;

    pfl_state_type q, d;

    logic [SYNC_W-1:0] pins;
    logic              tick;
    logic              cs_act;
    logic              strobe;
    logic              sby;
    logic              safe_force;
    logic              fail_rise;

    // pin gathering, active high for the control signals
    assign pins = {data_lines, addr_lines, timer_gate_one, timer_gate_zero, timer_clk_in,
                   battery_low, battery_supply, ~wr_n, ~rd_n, ~cs_n, ~supply_loss_n};

    // decoded synchronised pins
    assign tick       = (q.tick_cnt == CNT_W'(DEB_TICK_CYC - 1));
    assign cs_act     = q.s2[S_CS];
    assign strobe     = q.s2[S_RD] | q.s2[S_WR];
    assign sby        = q.s2[S_SBY];
    assign safe_force = q.safe_arm && (q.safe_cnt == CNT_W'(SAFE_CYC));

    // next-state logic
    always_comb begin
        d = q;
        d.s1 = pins;
        d.s2 = q.s1;

        // debounce: free tick, change only on two agreeing samples
        d.tick_cnt = tick ? '0 : q.tick_cnt + CNT_W'(1);                    // R21
        if (tick) begin
            d.samp = q.s2[S_FAIL];
            if (q.s2[S_FAIL] == q.samp) begin
                d.failing = q.samp;                                         // R1 R10
            end
        end

        // detection edge of the debounced failure, taken here to keep d out of a loop
        fail_rise = d.failing && !q.failing;

        // safety: count a strobe held continuously after the failure
        if (fail_rise) begin
            d.safe_arm = cs_act;                                            // R6
        end else if (!q.failing) begin
            d.safe_arm = 1'b0;
        end
        if (q.failing && strobe && !safe_force) begin
            d.safe_cnt = q.safe_cnt + CNT_W'(1);                            // R6
        end else if (!strobe || !q.failing) begin
            d.safe_cnt = '0;
        end

        // lock-out sequence
        unique case (q.mode)
            ST_RUN: begin
                d.win_cnt = '0;
                if (q.failing) begin
                    d.mode = lockout_delay_en ? ST_WINDOW : ST_LOCK_WAIT;   // R3 R4
                end
            end
            ST_WINDOW: begin
                d.win_cnt = q.win_cnt + WIN_W'(1);
                if (!q.failing) begin
                    d.mode = ST_RUN;
                end else if (safe_force) begin
                    d.mode = ST_LOCKED;                                     // R6
                end else if (!lockout_delay_en) begin
                    d.mode = ST_LOCK_WAIT;                                  // R5
                end else if (q.win_cnt == WIN_W'(WINDOW_CYC - 1)) begin
                    d.mode = ST_LOCK_WAIT;                                  // R4
                end
            end
            ST_LOCK_WAIT: begin
                if (!q.failing) begin
                    d.mode = ST_RUN;
                end else if (!cs_act || safe_force) begin
                    d.mode = ST_LOCKED;                                     // R20 R6
                end
            end
            ST_LOCKED: begin
                if (!q.failing) begin
                    d.mode = ST_RUN;                                        // R10
                end
            end
        endcase

        // isolation of the host bus and the timer pins
        if (d.mode == ST_LOCKED || sby) begin
            d.bus = '0;                                                     // R7
        end else begin
            d.bus = '{cs: q.s2[S_CS], rd: q.s2[S_RD], wr: q.s2[S_WR],
                      addr: q.s2[S_ADDR +: 5], data: q.s2[S_DATA +: 8]};
        end
        if (sby) begin
            d.tmr = '0;                                                     // R8
        end else begin
            d.tmr = '{tck: q.s2[S_TCK], gate0: q.s2[S_G0], gate1: q.s2[S_G1]};
        end

        // interrupt follows the debounced failure when enabled
        d.irq = d.failing && pf_irq_en;                                     // R2 R11

        // oscillator fail stays until the clock is started
        if (rtc_start_wr) begin
            d.rtc_start = 1'b1;
            d.osc_fail  = 1'b0;                                             // R14
        end
        if (single_wr) begin
            d.single = single_wr_val;                                       // R15
        end

        // time save: software writes, switchover to battery clears
        d.sby_prev = sby;
        if (ts_wr) begin
            d.ts_en = ts_wr_val;
        end else if (sby && !q.sby_prev) begin
            d.ts_en = 1'b0;                                                 // R17
        end

        // low battery only on main supply with detection enabled
        d.low_batt = pf_irq_en && !sby && q.s2[S_LOWB];                     // R12
    end

    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q           <= '0;
            q.mode      <= ST_RUN;
            q.osc_fail  <= OSC_FAIL_RST;                                    // R13
            q.rtc_start <= RTC_START_RST;                                   // R13
        end else begin
            q <= d;
        end
    end

    // outputs
    assign bus_view          = q.bus;
    assign tmr_view          = q.tmr;
    assign bus_locked        = (q.mode == ST_LOCKED);
    assign pf_status         = q.failing;                                   // R19
    assign pf_irq            = q.irq;
    assign low_batt_status   = q.low_batt;
    assign osc_fail          = q.osc_fail;
    assign rtc_start         = q.rtc_start;
    assign single_supply_bit = q.single;
    assign linear_on         = pf_irq_en && !q.s2[S_SBY];                  // R12 R18
    assign time_save_en      = q.ts_en;
    assign time_save_copy    = q.ts_en;                                     // R16
    assign timers_run        = !q.failing || timer_pf_op;                   // R9
    assign irq_logic_run     = !q.failing || irq_pf_op;                     // R9
    assign outputs_od        = q.s2[S_SBY];                                 // R8

    // assertions; run counters measure how long the synchronised pin held one level
    localparam int LOW_MIN = DEB_TICK_CYC;
    logic [CNT_W:0] low_run;
    logic [CNT_W:0] high_run;
    // cycles the pin has read failing without a break
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            low_run <= '0;
        end else if (!q.s2[S_FAIL]) begin
            low_run <= '0;
        end else if (low_run != '1) begin
            low_run <= low_run + (CNT_W+1)'(1);
        end
    end

    // cycles the pin has read healthy without a break
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            high_run <= '0;
        end else if (q.s2[S_FAIL]) begin
            high_run <= '0;
        end else if (high_run != '1) begin
            high_run <= high_run + (CNT_W+1)'(1);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_detect;
        $rose(q.failing);
    endsequence
    sequence s_open_window;
        q.mode == ST_WINDOW && !lockout_delay_en && !safe_force && q.failing;
    endsequence

    a_deb_long_low: assert property (s_detect |-> low_run >= LOW_MIN) // R1
        else $error("failure declared before the pin was low long enough");
    a_irq_raise: assert property ((s_detect and pf_irq_en) |=> pf_irq) // R2
        else $error("no interrupt after debounced failure");
    a_irq_masked: assert property (!pf_irq_en |=> !pf_irq) // R11
        else $error("interrupt raised while masked");
    a_fast_lock: assert property (s_detect ##1 (!lockout_delay_en && !cs_act)[*2] |=> bus_locked) // R3
        else $error("no prompt lock-out without delay option");
    a_window_open: assert property ((s_detect and lockout_delay_en) ##1 (lockout_delay_en && !safe_force)[*2] |=> !bus_locked) // R4
        else $error("bus locked inside the access window");
    a_window_cut: assert property (s_open_window ##1 (!cs_act && q.failing) |=> bus_locked) // R5
        else $error("clearing delay option did not lock the bus");
    a_safety_lock: assert property (safe_force && q.mode != ST_RUN && q.failing |=> bus_locked) // R6
        else $error("long strobe did not force lock-out");
    a_locked_quiet: assert property (bus_locked |-> bus_view == '0) // R7
        else $error("host bus visible while locked");
    a_standby_tmr: assert property (outputs_od |=> tmr_view == '0) // R8
        else $error("timer pins visible in standby");
    a_lock_holds: assert property (bus_locked && pf_status |=> bus_locked) // R10
        else $error("unlocked while supply still failing");
    a_lowbatt_gate: assert property (low_batt_status |-> $past(pf_irq_en)) // R12
        else $error("low battery reported while detection disabled");
    a_osc_hold: assert property (osc_fail && !rtc_start_wr |=> osc_fail) // R14
        else $error("oscillator fail cleared without clock start");
    a_ts_clear: assert property ($rose(q.s2[S_SBY]) && !ts_wr |=> !time_save_en) // R17
        else $error("time save not cleared on battery switchover");
    a_cs_gate: assert property (q.mode == ST_LOCK_WAIT && cs_act && !safe_force |=> !bus_locked) // R20
        else $error("lock-out cut an access in progress");
    a_standby_bus: assert property (outputs_od |=> bus_view == '0) // R7
        else $error("host bus visible in standby");
    a_deb_long_high: assert property ($fell(q.failing) |-> high_run >= LOW_MIN) // R10
        else $error("failure withdrawn before the pin was high long enough");
    a_unlock_run: assert property (bus_locked && !pf_status |=> !bus_locked) // R10
        else $error("lock-out kept after supply returned");
    a_lowbatt_sby: assert property (outputs_od |=> !low_batt_status) // R12
        else $error("low battery reported while on battery supply");
    a_osc_clear: assert property (rtc_start_wr |=> rtc_start && !osc_fail) // R14
        else $error("clock start did not clear the oscillator fail flag");
    a_irq_status: assert property (pf_irq |-> pf_status) // R2
        else $error("interrupt raised without a debounced failure");
endmodule
`default_nettype wire

// ==== pfl_host_model.sv ====
// Purpose: supply monitor and host bus model facing the lock-out controller
// Assumes: bench commands change just after a rising edge
// Notes:   released bus lines toggle so a stale value never passes for a held one
`timescale 1ns/1ps
`default_nettype none
module pfl_host_model (
    input  wire logic        clk,            // system clock
    input  wire logic        loss_cmd,       // 1: monitor reports supply loss
    input  wire logic        sby_cmd,        // 1: battery above main supply
    input  wire logic        acc_cmd,        // 1: hold a host access
    input  wire logic        acc_wr,         // 1: write access, 0: read
    input  wire logic [12:0] ad_cmd,         // address and data of the access
    output logic             supply_loss_n,  // monitor pin, low on loss
    output logic             battery_supply, // standby comparator
    output logic             cs_n,           // chip select pin
    output logic             rd_n,           // read strobe pin
    output logic             wr_n,           // write strobe pin
    output logic [4:0]       addr_lines,     // address pins
    output logic [7:0]       data_lines      // data pins
);
    // idle values at time zero
    initial begin
        {supply_loss_n, cs_n, rd_n, wr_n} = 4'hf;
        battery_supply = 1'b0;
        {addr_lines, data_lines} = 13'h0a5a;
    end
    // pins follow the commands one edge later; undriven lines toggle
    always @(posedge clk) begin
        supply_loss_n <= !loss_cmd;
        battery_supply <= sby_cmd;
        cs_n <= !acc_cmd;
        rd_n <= !(acc_cmd && !acc_wr);
        wr_n <= !(acc_cmd && acc_wr);
        addr_lines <= acc_cmd ? ad_cmd[12:8] : ~addr_lines;
        data_lines <= (acc_cmd && acc_wr) ? ad_cmd[7:0] : ~data_lines;
    end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: self-checking bench for the supply-loss lock-out controller
// Assumes: access window shortened to 50 cycles, debounce counts kept
// Notes:   random addresses, data, timer pins and glitch lengths from an lfsr
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pfl_pkg::*;
    localparam int WIN = 50;
    logic        clk = 1'b0, nrst = 1'b0, loss = 1'b0, sby = 1'b0, acc = 1'b0;
    logic        accw = 1'b0, blow = 1'b0, tck = 1'b0, g0 = 1'b0, g1 = 1'b0;
    logic        dly = 1'b0, irqen = 1'b1, tpo = 1'b0, ipo = 1'b1, rtcw = 1'b0;
    logic        sw = 1'b0, swv = 1'b0, tsw = 1'b0, tsv = 1'b0;
    logic [12:0] ad = 13'h0000;
    logic        sl_n, bs, cs_n, rd_n, wr_n;
    logic [4:0]  a_l;
    logic [7:0]  d_l;
    pfl_bus_type bv;
    pfl_tmr_type tv;
    logic        lk, pst, pirq, lbs, ofl, rsb, ssb, lin, tse, tsc, trun, irun, od;
    int          err_count = 0, n_checks = 0, n, k;
    logic [31:0] seed = 32'hf536f66a;

    // clock generation
    always #4 clk = ~clk;

    pfl_host_model pfl_host_model_inst (.clk(clk), .loss_cmd(loss), .sby_cmd(sby),
        .acc_cmd(acc), .acc_wr(accw), .ad_cmd(ad), .supply_loss_n(sl_n),
        .battery_supply(bs), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .addr_lines(a_l), .data_lines(d_l));
    pfl_ctrl #(.WINDOW_CYC(WIN)) pfl_ctrl_inst (.clk(clk), .nrst(nrst),
        .supply_loss_n(sl_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr_lines(a_l),
        .data_lines(d_l), .battery_supply(bs), .battery_low(blow), .timer_clk_in(tck),
        .timer_gate_zero(g0), .timer_gate_one(g1), .lockout_delay_en(dly),
        .pf_irq_en(irqen), .timer_pf_op(tpo), .irq_pf_op(ipo), .rtc_start_wr(rtcw),
        .single_wr(sw), .single_wr_val(swv), .ts_wr(tsw), .ts_wr_val(tsv),
        .bus_view(bv), .tmr_view(tv), .bus_locked(lk), .pf_status(pst), .pf_irq(pirq),
        .low_batt_status(lbs), .osc_fail(ofl), .rtc_start(rsb), .single_supply_bit(ssb),
        .linear_on(lin), .time_save_en(tse), .time_save_copy(tsc), .timers_run(trun),
        .irq_logic_run(irun), .outputs_od(od));

    // expectation helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [15:0] exp_bus(input logic locked, input logic [12:0] v);
        return locked ? 16'h0000 : {3'b101, v};
    endfunction

    // verdict and end of run
    task automatic summarize();
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_vec({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic chk_rng(input int v, input int lo, input int hi);
        n_checks++;
        if (v < lo || v > hi) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
        end
    endtask
    // bounded wait on pf_status (sel 0) or bus_locked (sel 1); n counts cycles
    task automatic wait_on(input int sel, input logic val, input int bound);
        n = 0;
        while (((sel == 0) ? pst : lk) !== val) begin
            tick(1);
            n++;
            if (n > bound) begin
                err_count++;
                $display("CHECK FAILED t=%0t wait got=%h exp=%h", $time, !val, val);
                summarize();
            end
        end
    endtask
    task automatic restore();
        loss <= 1'b0;
        wait_on(1, 1'b0, 7880);
        chk_rng(n, 3750, 7880);
        chk_bit(pst, 1'b0);
    endtask

    // main sequence
    initial begin
        tick(4);
        nrst <= 1'b1;
        tick(3);
        chk_bit(ofl, OSC_FAIL_RST);
        chk_bit(rsb, RTC_START_RST);
        // single supply bit writes, then clock start
        for (k = 1; k >= 0; k--) begin
            swv <= k[0];
            sw <= 1'b1;
            tick(1);
            sw <= 1'b0;
            tick(2);
            chk_bit(ssb, k[0]);
            chk_bit(ofl, 1'b1);
        end
        rtcw <= 1'b1;
        tick(1);
        rtcw <= 1'b0;
        tick(2);
        chk_bit(ofl, 1'b0);
        chk_bit(rsb, 1'b1);
        // low battery status and linear circuits follow the interrupt enable
        blow <= 1'b1;
        tick(5);
        chk_bit(lbs, 1'b1);
        irqen <= 1'b0;
        tick(5);
        chk_bit(lbs, 1'b0);
        chk_bit(lin, 1'b0);
        irqen <= 1'b1;
        // random writes and timer pins pass while powered
        for (k = 0; k < 8; k++) begin
            seed = lfsr(seed);
            ad <= seed[12:0];
            {acc, accw} <= 2'b11;
            {tck, g0, g1} <= seed[15:13];
            tick(5);
            chk_vec(bv, exp_bus(1'b0, seed[12:0]));
            chk_vec({13'h0000, tv}, {13'h0000, seed[15:13]});
            acc <= 1'b0;
            tick(1);
        end
        // short low glitch is ignored
        seed = lfsr(seed);
        loss <= 1'b1;
        tick(200 + int'(seed[10:0]));
        loss <= 1'b0;
        n = 0;
        repeat (8000) begin
            tick(1);
            if (pst !== 1'b0)
                n++;
        end
        chk_rng(n, 0, 0);
        // failure without delay, time save armed
        tsv <= 1'b1;
        tsw <= 1'b1;
        tick(1);
        tsw <= 1'b0;
        tick(2);
        chk_bit(tsc, 1'b1);
        loss <= 1'b1;
        wait_on(0, 1'b1, 7600);
        chk_rng(n, 3750, 7510);
        chk_bit(pirq, 1'b1);
        tick(1);
        chk_bit(pirq, 1'b1);
        chk_bit(trun, tpo);
        chk_bit(irun, ipo);
        wait_on(1, 1'b1, 6);
        seed = lfsr(seed);
        ad <= seed[12:0];
        {acc, accw} <= 2'b11;
        {tck, g0, g1} <= seed[15:13];
        tick(5);
        chk_vec(bv, exp_bus(1'b1, seed[12:0]));
        chk_vec({13'h0000, tv}, {13'h0000, seed[15:13]});
        chk_bit(tse, 1'b1);
        acc <= 1'b0;
        sby <= 1'b1;
        tick(5);
        chk_bit(tse, 1'b0);
        chk_bit(od, 1'b1);
        chk_vec({13'h0000, tv}, 16'h0000);
        sby <= 1'b0;
        tick(5);
        restore();
        // delayed lock-out with the interrupt masked
        irqen <= 1'b0;
        {tpo, ipo} <= 2'b10;
        dly <= 1'b1;
        loss <= 1'b1;
        wait_on(0, 1'b1, 7600);
        wait_on(1, 1'b1, 60);
        chk_rng(n, WIN, WIN + 6);
        chk_bit(pirq, 1'b0);
        chk_bit(trun, 1'b1);
        chk_bit(irun, 1'b0);
        restore();
        // host ends the window early by clearing the delay bit
        irqen <= 1'b1;
        loss <= 1'b1;
        wait_on(0, 1'b1, 7600);
        tick(10);
        chk_bit(lk, 1'b0);
        dly <= 1'b0;
        wait_on(1, 1'b1, 8);
        chk_rng(n, 1, 5);
        restore();
        // read held through the failure: safety forces the lock
        {acc, accw} <= 2'b10;
        tick(4);
        loss <= 1'b1;
        wait_on(0, 1'b1, 7600);
        wait_on(1, 1'b1, 3800);
        chk_rng(n, 3700, 3770);
        acc <= 1'b0;
        restore();
        summarize();
    end
endmodule
`default_nettype wire
